// >>> cond_mux_latch.sv
// condition mux, host command register and output latch with an avalon-mm slave
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`include "cond_latch_consts.svh"
`timescale 1ns/1ns
module cond_mux_latch (
  input  wire logic                          clk,
  input  wire logic                          srst,
  // avalon-mm register slave
  input  wire logic [7:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output cond_latch_pkg::bus_word_t          avs_readdata,
  output logic                               avs_waitrequest,
  output logic                               irq,
  // sequencer output lines, same clock
  input  wire cond_latch_pkg::cond_sel_t     cond_select,
  input  wire logic                          latch_enable,
  input  wire logic                          latch_value,
  input  wire logic                          latch_clear,
  input  wire logic                          clear_valid_cmd,
  // to the sequencer
  output logic                               condition,
  output cond_latch_pkg::cmd_code_t          branch_address_inputs,
  // pins from the buses
  input  wire logic                          disk_dma_ack,
  input  wire logic                          host_transfer_ack,
  input  wire logic                          ready_request_in,
  input  wire logic                          scsi_req_in,
  input  wire logic                          scsi_busy_in,
  input  wire logic                          scsi_msg_in,
  input  wire logic                          scsi_cd_in,
  input  wire logic                          scsi_parity_err_in,
  input  wire logic                          tape_ack_in,
  input  wire logic                          tape_exception_in,
  input  wire logic                          tape_ready_in,
  // host side outputs
  output logic                               host_wait_ready,
  output logic                               disk_message_flag,
  output logic                               host_interrupt_line,
  output logic                               host_transfer_req,
  // tape and scsi outputs
  output logic                               tape_online_out,
  output logic                               tape_reset_out,
  output logic                               scsi_ack_out,
  output logic                               scsi_atn_out,
  output logic                               scsi_rst_out
);

  // synchronised copies of the pins
  logic [`PIN_COUNT-1:0]          pins_raw;
  logic [`PIN_COUNT-1:0]          pins;
  logic                           dma_ack_s;
  logic                           xfer_ack_s;
  logic                           rdy_req_s;
  logic                           scsi_req_s;
  logic                           busy_s;
  logic                           msg_s;
  logic                           cd_s;
  logic                           parity_s;
  logic                           tape_ack_s;
  logic                           tape_exc_s;
  logic                           tape_rdy_s;

  // internal state
  cond_latch_pkg::latch_vec_t     latches;
  logic                           valid_command_flag;
  logic                           parity_latch;
  logic                           parity_prev;
  logic                           msg_prev;
  logic                           next_condition;
  logic                           next_wait_ready;
  logic                           next_msg_flag;
  logic [`EV_COUNT-1:0]           irq_status;
  logic [`EV_COUNT-1:0]           irq_mask;
  logic [`EV_COUNT-1:0]           events;
  logic                           bus_req;
  logic                           bus_take;
  logic                           cmd_write;
  logic                           cmd_accept;
  logic                           cmd_overrun;
  cond_latch_pkg::bus_word_t      read_word;

  // every pin crosses in through the three-stage filter
  assign pins_raw = {tape_ready_in, tape_exception_in, tape_ack_in, scsi_parity_err_in,
                     scsi_cd_in, scsi_msg_in, scsi_busy_in, scsi_req_in,
                     ready_request_in, host_transfer_ack, disk_dma_ack};

  pin_sync #(
    .WIDTH (`PIN_COUNT)
  ) u_pin_sync (
    .clk   (clk),
    .srst  (srst),
    .pin   (pins_raw),
    .level (pins)
  );

  // unpack the filtered levels
  assign dma_ack_s  = pins[0];
  assign xfer_ack_s = pins[1];
  assign rdy_req_s  = pins[2];
  assign scsi_req_s = pins[3];
  assign busy_s     = pins[4];
  assign msg_s      = pins[5];
  assign cd_s       = pins[6];
  assign parity_s   = pins[7];
  assign tape_ack_s = pins[8];
  assign tape_exc_s = pins[9];
  assign tape_rdy_s = pins[10];

  // condition selection; host_transfer_req and the ready interrupt enable feed back
  always_comb
  begin
    case (cond_select)
      `SEL_VALID_CMD:  next_condition = valid_command_flag;            // see R2 see R9
      `SEL_DMA_ACK:    next_condition = dma_ack_s;                     // see R2
      `SEL_SCSI_REQ:   next_condition = scsi_req_s;                    // see R2
      `SEL_TAPE_ACK:   next_condition = tape_ack_s;                    // see R2
      `SEL_XFER_BOTH:  next_condition = xfer_ack_s & host_transfer_req;  // see R3
      `SEL_XFER_ACK:   next_condition = xfer_ack_s & ~host_transfer_req; // see R3
      `SEL_MSG_TRDY:   next_condition = (msg_s & cd_s)
                                        | (latches[`LT_TAPE_RDY_IE] & tape_rdy_s); // see R3
      `SEL_TAPE_EXC:   next_condition = tape_exc_s;                    // see R2
      `SEL_SCSI_BUSY:  next_condition = busy_s;                        // see R2
      `SEL_ONE:        next_condition = 1'b1;                          // see R2
      `SEL_HOST_ACK:   next_condition = xfer_ack_s;                    // see R2
      `SEL_REQ_DMA:    next_condition = scsi_req_s & dma_ack_s;        // see R3
      `SEL_TAPE_READY: next_condition = tape_rdy_s;                    // see R2
      default:         next_condition = 1'b0;                          // see R4
    endcase
  end

  // registered so the sequencer samples a value settled a whole cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      condition <= 1'b0;
    else
      condition <= next_condition;                                     // see R1 see R12
  end

  // wait stretch and disk message, formed from the filtered pins
  assign next_wait_ready = rdy_req_s | (~dma_ack_s & ~rdy_req_s);     // see R5
  assign next_msg_flag   = msg_s & cd_s;                               // see R6

  // the filter already adds delay, so one more flop keeps outputs glitch free
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      host_wait_ready   <= 1'b1;
      disk_message_flag <= 1'b0;
    end
    else
    begin
      host_wait_ready   <= next_wait_ready;                            // see R5
      disk_message_flag <= next_msg_flag;                              // see R6
    end
  end

  // avalon handshake: one wait cycle, then the request is taken
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;

  always_ff @(posedge clk)
  begin
    if (srst)
      avs_waitrequest <= 1'b1;
    else if (bus_req & avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // a command write needs the low byte lane
  assign cmd_write   = bus_take & avs_write & avs_byteenable[0]
                       & (avs_address == `OFS_COMMAND);
  // a command arriving while one is pending is refused, never merged
  assign cmd_accept  = cmd_write & ~valid_command_flag;                // see R13
  assign cmd_overrun = cmd_write & valid_command_flag;

  // command code holds still while the flag is set, so the branch target is stable
  always_ff @(posedge clk)
  begin
    if (srst)
      branch_address_inputs <= 6'h00;
    else if (cmd_accept)
      branch_address_inputs <= avs_writedata[5:0];                     // see R8 see R9
  end

  // valid flag: the host write sets it, the sequencer's done line clears it
  always_ff @(posedge clk)
  begin
    if (srst)
      valid_command_flag <= 1'b0;
    else if (cmd_accept)
      valid_command_flag <= 1'b1;                                      // see R8
    else if (clear_valid_cmd)
      valid_command_flag <= 1'b0;                                      // see R10
  end

  // parity error latch sits in the seventh command bit; set wins over clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      parity_latch <= 1'b0;
      parity_prev  <= 1'b0;
    end
    else
    begin
      parity_prev <= parity_s;
      if (parity_s & ~parity_prev)
        parity_latch <= 1'b1;                                          // see R11
      else if (cmd_write & avs_writedata[`CMD_PARITY_BIT])
        parity_latch <= 1'b0;
    end
  end

  // remember the message level to raise an event on its rising edge
  always_ff @(posedge clk)
  begin
    if (srst)
      msg_prev <= 1'b0;
    else
      msg_prev <= next_msg_flag;
  end

  // events for the sticky interrupt status
  always_comb
  begin
    events                  = '0;
    events[`EV_DISK_MSG]    = next_msg_flag & ~msg_prev;               // see R7
    events[`EV_CMD_DONE]    = clear_valid_cmd & valid_command_flag;
    events[`EV_CMD_OVERRUN] = cmd_overrun;
    events[`EV_PARITY]      = parity_s & ~parity_prev;
  end

  // write one to clear; a new event in the same cycle keeps its bit set
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_status <= '0;
    else if (bus_take & avs_write & avs_byteenable[0]
             & (avs_address == `OFS_IRQ_STATUS))
      irq_status <= (irq_status & ~avs_writedata[`EV_COUNT-1:0]) | events;
    else
      irq_status <= irq_status | events;
  end

  // interrupt mask register
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_mask <= '0;
    else if (bus_take & avs_write & avs_byteenable[0]
             & (avs_address == `OFS_IRQ_MASK))
      irq_mask <= avs_writedata[`EV_COUNT-1:0];
  end

  // one level interrupt line
  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    read_word = 32'h0000_0000;
    case (avs_address)
      `OFS_COMMAND:
      begin
        read_word[5:0]             = branch_address_inputs;
        read_word[`CMD_PARITY_BIT] = parity_latch;                     // see R11
        read_word[`CMD_VALID_BIT]  = valid_command_flag;
      end
      `OFS_STATUS:
      begin
        read_word[7:0]          = latches;
        read_word[`ST_COND_BIT] = condition;
        read_word[`ST_MSG_BIT]  = disk_message_flag;                   // see R6
        read_word[`ST_WAIT_BIT] = host_wait_ready;
      end
      `OFS_IRQ_STATUS: read_word[`EV_COUNT-1:0] = irq_status;
      `OFS_IRQ_MASK:   read_word[`EV_COUNT-1:0] = irq_mask;
      default:         read_word = 32'h0000_0000;
    endcase
  end

  // read data is loaded as the wait cycle ends and stands at the taking edge
  always_ff @(posedge clk)
  begin
    if (srst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & avs_waitrequest)
      avs_readdata <= read_word;
  end

  // the latch address shares select lines three to one with the mux field
  output_latch u_output_latch (
    .clk         (clk),
    .srst        (srst),
    .latch_clear (latch_clear),                                        // see R18
    .addr        (cond_select[3:1]),                                   // see R15
    .enable      (latch_enable),                                       // see R16
    .value       (latch_value),
    .q           (latches)                                             // see R14
  );

  // latch entries out to the pins, one flop each so outputs stay clean
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      host_interrupt_line <= 1'b0;
      host_transfer_req   <= 1'b0;
      tape_online_out     <= 1'b0;
      tape_reset_out      <= 1'b0;
      scsi_ack_out        <= 1'b0;
      scsi_atn_out        <= 1'b0;
      scsi_rst_out        <= 1'b0;
    end
    else
    begin
      host_interrupt_line <= latches[`LT_HOST_INT];                    // see R7 see R19
      host_transfer_req   <= latches[`LT_XFER_REQ];                    // see R19
      tape_online_out     <= latches[`LT_TAPE_ONLINE];                 // see R19
      tape_reset_out      <= latches[`LT_TAPE_RESET];                  // see R19
      scsi_ack_out        <= latches[`LT_SCSI_ACK];                    // see R19
      scsi_atn_out        <= latches[`LT_SCSI_ATN];                    // see R19
      scsi_rst_out        <= latches[`LT_SCSI_RST];                    // see R19
    end
  end
endmodule

// >>> cond_latch_consts.svh
// constants for the condition mux, command register and output latch block
// What this block does
// R1: condition result is registered before it reaches the sequencer condition input
// R2: four-bit select picks one plain test input or constant one
// R3: select codes 4, 5, 6 and 11 pick logical combinations of inputs
// R4: select codes 13 to 15 give a deasserted condition
// R5: host_wait_ready high when ready request high, or dma ack and request both low
// R6: disk_message_flag follows MSG and C/D together, readable by the host
// R7: disk message leads the sequencer to raise host_interrupt_line via the latch
// R8: host writes a six-bit command code, which sets valid_command_flag
// R9: idle loop tests the valid flag and branches to the six command bits
// R10: sequencer clears valid_command_flag after the command, then returns to idle
// R11: seventh command register bit is the SCSI parity error latch
// R12: sequencer runs one instruction per clock; its outputs may change each cycle
// R13: command flag handshake tolerates a slower host running asynchronously
// R14: persistent control outputs live in an eight-entry addressable latch
// R15: three select lines shared with the mux field address the latch
// R16: enable line writes the value line into the addressed latch on the clock
// R17: with enable low no latch changes; unaddressed latches never change (here latch_clear and srst still empty all eight)
// R18: latch_clear asynchronously resets all eight latches
// R19: latches drive interrupt, transfer request, tape, SCSI and mux feedback lines
`ifndef COND_LATCH_CONSTS_SVH
`define COND_LATCH_CONSTS_SVH

// register byte offsets
`define OFS_COMMAND    8'h00
`define OFS_STATUS     8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK   8'h0c

// command register fields
`define CMD_PARITY_BIT 6
`define CMD_VALID_BIT  7

// status register fields
`define ST_COND_BIT    8
`define ST_MSG_BIT     9
`define ST_WAIT_BIT    10

// interrupt event bits
`define EV_DISK_MSG    0
`define EV_CMD_DONE    1
`define EV_CMD_OVERRUN 2
`define EV_PARITY      3
`define EV_COUNT       4

// condition select codes
`define SEL_VALID_CMD  4'h0
`define SEL_DMA_ACK    4'h1
`define SEL_SCSI_REQ   4'h2
`define SEL_TAPE_ACK   4'h3
`define SEL_XFER_BOTH  4'h4
`define SEL_XFER_ACK   4'h5
`define SEL_MSG_TRDY   4'h6
`define SEL_TAPE_EXC   4'h7
`define SEL_SCSI_BUSY  4'h8
`define SEL_ONE        4'h9
`define SEL_HOST_ACK   4'ha
`define SEL_REQ_DMA    4'hb
`define SEL_TAPE_READY 4'hc

// output latch entries
`define LT_SCSI_ATN    3'h0
`define LT_SCSI_RST    3'h1
`define LT_HOST_INT    3'h2
`define LT_XFER_REQ    3'h3
`define LT_TAPE_ONLINE 3'h4
`define LT_TAPE_RDY_IE 3'h5
`define LT_TAPE_RESET  3'h6
`define LT_SCSI_ACK    3'h7

// pin synchroniser width
`define PIN_COUNT      11

`endif

// >>> cond_latch_pkg.sv
// shared types of the condition mux and output latch block
package cond_latch_pkg;
  typedef logic [3:0]  cond_sel_t;
  typedef logic [5:0]  cmd_code_t;
  typedef logic [7:0]  latch_vec_t;
  typedef logic [31:0] bus_word_t;
endpackage

// >>> pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 is only read by stage2, never by logic
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit moves only when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (srst)
      level <= '0;
    else
      for (int i = 0; i < WIDTH; i++)
        if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
  end
endmodule

// >>> output_latch.sv
// eight-entry addressable set/clear latch for persistent control outputs
`timescale 1ns/1ns
module output_latch (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   latch_clear,
  input  wire logic [2:0]             addr,
  input  wire logic                   enable,
  input  wire logic                   value,
  output cond_latch_pkg::latch_vec_t  q
);
  // clear is asynchronous so the power-on instruction empties every entry at once
  always_ff @(posedge clk or posedge latch_clear)
  begin
    if (latch_clear)
      q <= 8'h00;                         // see R18
    else if (srst)
      q <= 8'h00;
    else if (enable)
      q[addr] <= value;                   // see R16 see R17
  end
endmodule

// >>> pin_driver_model.sv
// far-side model of the host, disk and tape pins feeding the block
`timescale 1ns/1ns
module pin_driver_model (
  input  wire logic        clk,
  input  wire logic [10:0] pin_cmd,
  output logic             disk_dma_ack,
  output logic             host_transfer_ack,
  output logic             ready_request_in,
  output logic             scsi_req_in,
  output logic             scsi_busy_in,
  output logic             scsi_msg_in,
  output logic             scsi_cd_in,
  output logic             scsi_parity_err_in,
  output logic             tape_ack_in,
  output logic             tape_exception_in,
  output logic             tape_ready_in
);
  // far side moves its lines a cycle after the bench asks; order dma ack to tape ready
  always @(posedge clk)
  begin
    {disk_dma_ack, host_transfer_ack, ready_request_in, scsi_req_in, scsi_busy_in,
     scsi_msg_in, scsi_cd_in, scsi_parity_err_in, tape_ack_in, tape_exception_in,
     tape_ready_in} <= pin_cmd;
  end
endmodule

// >>> cond_mux_latch_properties.sv
// port assertions for the condition mux and output latch block
`include "cond_latch_consts.svh"
`timescale 1ns/1ns
module cond_mux_latch_properties (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [3:0] cond_select,
  input wire logic       latch_enable,
  input wire logic       latch_value,
  input wire logic       latch_clear,
  input wire logic       condition,
  input wire logic       disk_dma_ack,
  input wire logic       ready_request_in,
  input wire logic       scsi_req_in,
  input wire logic       scsi_msg_in,
  input wire logic       scsi_cd_in,
  input wire logic       host_wait_ready,
  input wire logic       disk_message_flag,
  input wire logic       host_interrupt_line,
  input wire logic       host_transfer_req,
  input wire logic       tape_online_out,
  input wire logic       tape_reset_out,
  input wire logic       scsi_ack_out,
  input wire logic       scsi_atn_out,
  input wire logic       scsi_rst_out
);
  logic [4:0] pins, pin_prev;
  logic [2:0] quiet;
  logic       settled;
  logic [6:0] outs;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // pins must sit still past the synchroniser depth before values compare
  assign pins = {disk_dma_ack, ready_request_in, scsi_req_in, scsi_msg_in, scsi_cd_in};
  assign settled = (quiet == 3'h7) && (pins == pin_prev);
  assign outs = {host_interrupt_line, host_transfer_req, tape_online_out, tape_reset_out,
                 scsi_ack_out, scsi_atn_out, scsi_rst_out};

  // previous pin sample
  always_ff @(posedge clk)
  begin
    pin_prev <= pins;
  end

  // cycles without a pin change, saturating
  always_ff @(posedge clk)
  begin
    if (srst || (pins != pin_prev))
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end

  sequence s_int_write;
    latch_enable && !latch_clear && (cond_select[3:1] == 3'h2);
  endsequence

  sequence s_latch_idle;
    (!latch_enable && !latch_clear) ##1 !latch_clear;
  endsequence

  a_one_pass: assert property (cond_select == `SEL_ONE |=> condition)
    else $error("select one gave no pass");
  a_unassigned_low: assert property (cond_select >= 4'hd |=> !condition)
    else $error("unassigned select gave a pass");
  a_dma_select: assert property (cond_select == `SEL_DMA_ACK && settled
    |=> condition == $past(disk_dma_ack)) else $error("dma ack select wrong");
  a_req_and_dma: assert property (cond_select == `SEL_REQ_DMA && settled
    |=> condition == $past(scsi_req_in && disk_dma_ack)) else $error("req and ack wrong");
  a_wait_ready: assert property (settled
    |-> host_wait_ready == (ready_request_in || !disk_dma_ack)) else $error("wait ready wrong");
  a_msg_flag: assert property (settled
    |-> disk_message_flag == (scsi_msg_in && scsi_cd_in)) else $error("message flag wrong");
  a_latch_write: assert property (s_int_write ##1 !latch_clear
    |=> host_interrupt_line == $past(latch_value, 2)) else $error("latch write lost");
  a_latch_hold: assert property (s_latch_idle |=> $stable(outs))
    else $error("latch moved unwritten");
  a_clear_all: assert property (latch_clear |=> outs == 7'h00)
    else $error("clear left an output set");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("bus request not answered");
endmodule

bind cond_mux_latch cond_mux_latch_properties chk_u (.*);

// >>> condition_mux_and_output_latch_test.sv
// self-checking bench for the condition mux and output latch block
`include "cond_latch_consts.svh"
`timescale 1ns/1ns
module condition_mux_and_output_latch_test;
  logic        clk = 1'b0, srst = 1'b1;
  logic [7:0]  avs_address = 8'h00, outv, ev;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hf, cond_select = 4'h0;
  logic [5:0]  branch_address_inputs;
  logic        latch_enable = 1'b0, latch_value = 1'b0, latch_clear = 1'b0;
  logic        clear_valid_cmd = 1'b0;
  logic [10:0] pin_cmd = 11'h000;
  logic avs_waitrequest, irq, condition, host_wait_ready, disk_message_flag;
  logic host_interrupt_line, host_transfer_req, tape_online_out, tape_reset_out;
  logic scsi_ack_out, scsi_atn_out, scsi_rst_out, disk_dma_ack, host_transfer_ack;
  logic ready_request_in, scsi_req_in, scsi_busy_in, scsi_msg_in, scsi_cd_in;
  logic scsi_parity_err_in, tape_ack_in, tape_exception_in, tape_ready_in;
  logic [10:0] pats [4] = '{11'h000, 11'h2b5, 11'h542, 11'h681};
  int          n_errors = 0, compares = 0, cycles = 0;

  cond_mux_latch dut_u (.*);
  pin_driver_model pm_u (.*);

  always #50 clk = ~clk;

  // latch outputs in entry order; entry 5 stays inside the block
  assign outv = {scsi_ack_out, tape_reset_out, 1'b0, tape_online_out, host_transfer_req,
                 host_interrupt_line, scsi_rst_out, scsi_atn_out};

  task automatic results;
    $display("compares %0d errors %0d", compares, n_errors);
    if ((n_errors == 0) && (compares > 0))
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, well above the run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, then one idle edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // sequencer-style single-cycle latch write
  task automatic latch_wr(input logic [2:0] a, input logic v);
    cond_select <= {a, 1'b0};
    latch_enable <= 1'b1;
    latch_value <= v;
    @(posedge clk);
    latch_enable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse_clear;
    clear_valid_cmd <= 1'b1;
    tick(1);
    clear_valid_cmd <= 1'b0;
    tick(3);
  endtask

  // expected condition; f is valid flag, ready int enable and transfer req
  function automatic logic cond_exp(input logic [3:0] s, input logic [10:0] p, input logic f);
    case (s)
      4'h0: return f;
      4'h1: return p[10];
      4'h2: return p[7];
      4'h3: return p[2];
      4'h4: return p[9] && f;
      4'h5: return p[9] && !f;
      4'h6: return (p[5] && p[4]) || (f && p[0]);
      4'h7: return p[1];
      4'h8: return p[6];
      4'h9: return 1'b1;
      4'ha: return p[9];
      4'hb: return p[7] && p[10];
      4'hc: return p[0];
      default: return 1'b0;
    endcase
  endfunction

  initial
  begin
    tick(8);
    srst <= 1'b0;
    tick(2);
    expect_reg(`OFS_STATUS, 32'h400);
    avs_byteenable <= 4'he;
    bus(1'b1, `OFS_IRQ_MASK, 32'hf);
    avs_byteenable <= 4'hf;
    expect_reg(`OFS_IRQ_MASK, 32'h0);
    expect_reg(8'h10, 32'h0);
    // command load, refusal while busy, completion
    bus(1'b1, `OFS_COMMAND, 32'h2a);
    check({26'h0, branch_address_inputs}, 32'h2a);
    expect_reg(`OFS_COMMAND, 32'haa);
    tick(3);
    check(32'(condition), 32'h1);
    bus(1'b1, `OFS_COMMAND, 32'h15);
    expect_reg(`OFS_COMMAND, 32'haa);
    pulse_clear();
    check(32'(condition), 32'h0);
    expect_reg(`OFS_COMMAND, 32'h2a);
    expect_reg(`OFS_IRQ_STATUS, 32'h6);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h6);
    expect_reg(`OFS_IRQ_STATUS, 32'h0);
    // parity error caught in the seventh command bit
    pin_cmd <= 11'h008;
    tick(8);
    pin_cmd <= 11'h000;
    tick(8);
    expect_reg(`OFS_COMMAND, 32'h6a);
    bus(1'b1, `OFS_COMMAND, 32'h40);
    expect_reg(`OFS_COMMAND, 32'h80);
    pulse_clear();
    bus(1'b1, `OFS_IRQ_STATUS, 32'hf);
    // disk message raises, masks and clears the interrupt
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    pin_cmd <= 11'h030;
    tick(10);
    check(32'(disk_message_flag), 32'h1);
    check(32'(irq), 32'h1);
    expect_reg(`OFS_IRQ_STATUS, 32'h1);
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    tick(2);
    check(32'(irq), 32'h0);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    expect_reg(`OFS_IRQ_STATUS, 32'h0);
    // every latch set, then even ones cleared; others must not move
    pin_cmd <= 11'h000;
    ev = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      ev[i[2:0]] = !i[3] || i[0];
      latch_wr(i[2:0], ev[i[2:0]]);
      tick(1);
      check(32'(outv), 32'(ev & 8'hdf));
    end
    bus(1'b0, `OFS_STATUS, 32'h0);
    check(rd & 32'hff, 32'haa);
    latch_clear <= 1'b1;
    tick(1);
    latch_clear <= 1'b0;
    tick(2);
    check(32'(outv), 32'h0);
    // every select over four pin patterns, feedback latches off then on
    for (int ph = 0; ph < 2; ph++)
    begin
      latch_wr(3'h3, ph[0]);
      latch_wr(3'h5, ph[0]);
      if (ph == 1)
        bus(1'b1, `OFS_COMMAND, 32'h3f);
      foreach (pats[p])
      begin
        pin_cmd <= pats[p];
        tick(10);
        check(32'(host_wait_ready), 32'(pats[p][8] || !pats[p][10]));
        check(32'(disk_message_flag), 32'(pats[p][5] && pats[p][4]));
        for (int s = 0; s < 16; s++)
        begin
          cond_select <= s[3:0];
          tick(3);
          check(32'(condition), 32'(cond_exp(s[3:0], pats[p], ph[0])));
        end
      end
    end
    pulse_clear();
    results();
  end
endmodule
